// file: src/bridge_upper_cfg.svh
`ifndef BRIDGE_UPPER_CFG_SVH
`define BRIDGE_UPPER_CFG_SVH

// Dword byte offsets in configuration space
`define OFS_PF_BASE_HIGH 8'h28
`define OFS_PF_LIMIT_HIGH 8'h2C
`define OFS_IO_HIGH 8'h30
`define OFS_CAP_PTR 8'h34
`define OFS_ROM_BASE 8'h38
`define OFS_INTR_BCTL 8'h3C

// Reset and fixed values
`define RST_PF_BASE_HIGH 32'h0000_0000
`define RST_PF_LIMIT_HIGH 32'h0000_0000
`define RST_IO_BASE_HIGH 16'h0000
`define RST_IO_LIMIT_HIGH 16'h0000
`define RST_INTR_ROUTE 8'h00
`define RST_BCTL 16'h0000
`define VAL_CAP_PTR 8'h80
`define VAL_ROM_BASE 32'h0000_0000
`define VAL_INTR_PIN 8'h00
`define VAL_ALL_ONES 32'hFFFF_FFFF

// Bridge control fields, positions within the upper half-word
`define BCTL_PARITY_RESP 0
`define BCTL_SEC_SERR_EN 1
`define BCTL_ISA_EN 2
`define BCTL_VGA_EN 3
`define BCTL_MA_MODE 5
`define BCTL_SEC_RESET 6
`define BCTL_PRI_SHORT 8
`define BCTL_SEC_SHORT 9
`define BCTL_DISCARD_STS 10
`define BCTL_DISCARD_SERR 11
`define BCTL_RW_MASK 16'h0B6F

// Discard timer lengths as powers of two of PCI clocks
`define DISCARD_LONG_EXP 15
`define DISCARD_SHORT_EXP 10

// Legacy VGA decode
`define VGA_MEM_LO 64'h0000_0000_000A_0000
`define VGA_MEM_HI 64'h0000_0000_000B_FFFF
`define VGA_IO_A_LO 10'h3B0
`define VGA_IO_A_HI 10'h3BB
`define VGA_IO_B_LO 10'h3C0
`define VGA_IO_B_HI 10'h3DF

`endif

// file: src/bridge_upper_pkg.sv
package bridge_upper_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic non_posted;
    logic pcix;
    logic ta_possible;
  } abort_evt_t;

  typedef struct packed {
    logic all_ones;
    logic discard_write;
    logic target_abort;
    logic split_completion;
    logic [31:0] fill_data;
  } abort_resp_t;

  typedef struct packed {
    logic is_io;
    logic is_mem;
    logic [63:0] addr;
  } fwd_query_t;

  typedef struct packed {
    logic [3:0] io_base_low;
    logic [3:0] io_limit_low;
    logic [11:0] pf_base_low;
    logic [11:0] pf_limit_low;
    logic mem_window_hit;
    logic io_enable;
    logic mem_enable;
    logic serr_enable;
  } lower_hdr_t;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN = 2'b10
  } tmr_state_t;

endpackage : bridge_upper_pkg

// file: src/bridge_config_upper_header.sv
`timescale 1ns/100ps
`include "bridge_upper_cfg.svh"
module bridge_config_upper_header #(
  parameter int unsigned LONG_DISCARD_CYCLES = 32'd1 << `DISCARD_LONG_EXP
) (
  input wire logic clock,
  input wire logic rst,
  input wire bridge_upper_pkg::cfg_req_t cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic primary_pcix_mode,
  input wire logic secondary_pcix_mode,
  input wire logic [1:0] discard_start,
  input wire logic [1:0] discard_done,
  input wire bridge_upper_pkg::lower_hdr_t lower_hdr,
  input wire bridge_upper_pkg::abort_evt_t abort_evt,
  output bridge_upper_pkg::abort_resp_t abort_resp,
  input wire bridge_upper_pkg::fwd_query_t fwd_query,
  output logic fwd_downstream,
  output logic fwd_upstream,
  input wire logic secondary_system_error_in,
  input wire logic secondary_parity_err,
  output logic secondary_parity_detected,
  output logic primary_system_error_out,
  output logic secondary_reset_n
);
  import bridge_upper_pkg::*;

  localparam logic [15:0] LONG_CNT = 16'(LONG_DISCARD_CYCLES);
  localparam logic [15:0] SHORT_CNT = 16'(32'd1 << `DISCARD_SHORT_EXP);

  function automatic logic [31:0] merge_be(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_be

  function automatic logic in_range(
    input logic [63:0] val,
    input logic [63:0] lo,
    input logic [63:0] hi
  );
    return (val >= lo) && (val <= hi);
  endfunction : in_range

  // Register state
  logic [31:0] pf_base_high_ff;
  logic [31:0] pf_limit_high_ff;
  logic [15:0] io_base_high_ff;
  logic [15:0] io_limit_high_ff;
  logic [7:0] intr_route_ff;
  logic [15:0] bctl_ff;
  logic cfg_ack_ff;
  logic [31:0] cfg_rdata_ff;

  // Address decode
  wire logic [31:0] wr_data = cfg_req.wdata;
  wire logic [3:0] wr_be = cfg_req.byte_en;
  wire logic sel_pfb = cfg_req.offset == `OFS_PF_BASE_HIGH;
  wire logic sel_pfl = cfg_req.offset == `OFS_PF_LIMIT_HIGH;
  wire logic sel_io = cfg_req.offset == `OFS_IO_HIGH;
  wire logic sel_cap = cfg_req.offset == `OFS_CAP_PTR;
  wire logic sel_rom = cfg_req.offset == `OFS_ROM_BASE;
  wire logic sel_ib = cfg_req.offset == `OFS_INTR_BCTL;
  wire logic wr_pfb = cfg_req.wr && sel_pfb;
  wire logic wr_pfl = cfg_req.wr && sel_pfl;
  wire logic wr_io = cfg_req.wr && sel_io;
  wire logic wr_ib = cfg_req.wr && sel_ib;

  wire logic [31:0] io_word = {io_limit_high_ff, io_base_high_ff};
  wire logic [31:0] ib_word = {bctl_ff, `VAL_INTR_PIN, intr_route_ff};
  wire logic [31:0] nxt_pfb = merge_be(pf_base_high_ff, wr_data, wr_be);
  wire logic [31:0] nxt_pfl = merge_be(pf_limit_high_ff, wr_data, wr_be);
  wire logic [31:0] io_merged = merge_be(io_word, wr_data, wr_be);
  wire logic [31:0] ib_merged = merge_be(ib_word, wr_data, wr_be);

  // Read mux; offsets outside this block read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_pfb) begin
      rd_mux = pf_base_high_ff;
    end
    if (sel_pfl) begin
      rd_mux = pf_limit_high_ff;
    end
    if (sel_io) begin
      rd_mux = io_word;
    end
    if (sel_cap) begin
      rd_mux = {24'h00_0000, `VAL_CAP_PTR};
    end
    if (sel_rom) begin
      rd_mux = `VAL_ROM_BASE;
    end
    if (sel_ib) begin
      rd_mux = ib_word;
    end
  end

  // Discard timers, index 0 primary, 1 secondary
  tmr_state_t tmr_state_ff [2];
  tmr_state_t nxt_tmr_state [2];
  logic [15:0] tmr_cnt_ff [2];
  logic [15:0] nxt_tmr_cnt [2];
  logic [1:0] expire_ff;
  logic [1:0] nxt_expire;
  wire logic [1:0] tmr_pcix = {secondary_pcix_mode, primary_pcix_mode};
  wire logic [1:0] tmr_short = {bctl_ff[`BCTL_SEC_SHORT], bctl_ff[`BCTL_PRI_SHORT]};

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      nxt_tmr_state[t] = tmr_state_ff[t];
      nxt_tmr_cnt[t] = tmr_cnt_ff[t];
      nxt_expire[t] = 1'b0;
      unique case (tmr_state_ff[t])
        TMR_IDLE: begin
          // Timers do not run in PCI-X mode, so the length bit is moot there
          if (discard_start[t] && !tmr_pcix[t]) begin
            nxt_tmr_state[t] = TMR_RUN;
            nxt_tmr_cnt[t] = (tmr_short[t] ? SHORT_CNT : LONG_CNT) - 16'h0001;
          end
        end
        TMR_RUN: begin
          if (discard_done[t] || tmr_pcix[t]) begin
            nxt_tmr_state[t] = TMR_IDLE;
          end else if (tmr_cnt_ff[t] == 16'h0000) begin
            nxt_tmr_state[t] = TMR_IDLE;
            nxt_expire[t] = 1'b1;
          end else begin
            nxt_tmr_cnt[t] = tmr_cnt_ff[t] - 16'h0001;
          end
        end
        default: begin
          nxt_tmr_state[t] = TMR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int t = 0; t < 2; t++) begin
        tmr_state_ff[t] <= TMR_IDLE;
        tmr_cnt_ff[t] <= 16'h0000;
      end
      expire_ff <= 2'b00;
    end else begin
      tmr_state_ff <= nxt_tmr_state;
      tmr_cnt_ff <= nxt_tmr_cnt;
      expire_ff <= nxt_expire;
    end
  end

  // Bridge control update
  wire logic any_expire = |expire_ff;
  wire logic bctl_w1c = wr_ib && wr_be[3] && wr_data[16 + `BCTL_DISCARD_STS];
  wire logic sts_set = any_expire && !primary_pcix_mode;
  logic [15:0] nxt_bctl;
  always_comb begin
    nxt_bctl = bctl_ff;
    if (wr_ib) begin
      nxt_bctl = ib_merged[31:16] & `BCTL_RW_MASK;
      nxt_bctl[`BCTL_DISCARD_STS] = bctl_ff[`BCTL_DISCARD_STS];
    end
    if (bctl_w1c) begin
      nxt_bctl[`BCTL_DISCARD_STS] = 1'b0;
    end
    if (sts_set) begin
      nxt_bctl[`BCTL_DISCARD_STS] = 1'b1;
    end
    if (primary_pcix_mode) begin
      nxt_bctl[`BCTL_DISCARD_STS] = 1'b0;
    end
  end

  // One process per register, except the shared I/O base and limit pair, keeps each write path easy to follow
  always_ff @(posedge clock) begin
    if (rst) begin
      pf_base_high_ff <= `RST_PF_BASE_HIGH;
    end else if (wr_pfb) begin
      pf_base_high_ff <= nxt_pfb;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pf_limit_high_ff <= `RST_PF_LIMIT_HIGH;
    end else if (wr_pfl) begin
      pf_limit_high_ff <= nxt_pfl;
    end
  end

  // Base and limit share one dword, so byte enables split them
  always_ff @(posedge clock) begin
    if (rst) begin
      io_base_high_ff <= `RST_IO_BASE_HIGH;
      io_limit_high_ff <= `RST_IO_LIMIT_HIGH;
    end else if (wr_io) begin
      io_base_high_ff <= io_merged[15:0];
      io_limit_high_ff <= io_merged[31:16];
    end
  end

  // Routing byte is plain storage; only configuration reads return it
  always_ff @(posedge clock) begin
    if (rst) begin
      intr_route_ff <= `RST_INTR_ROUTE;
    end else if (wr_ib) begin
      intr_route_ff <= ib_merged[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bctl_ff <= `RST_BCTL;
    end else begin
      bctl_ff <= nxt_bctl;
    end
  end

  // Every request is answered, even to unmapped offsets
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ack_ff <= 1'b0;
    end else begin
      cfg_ack_ff <= cfg_req.rd || cfg_req.wr;
    end
  end

  // Read data reads zero outside a read so stale values never linger
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_rdata_ff <= cfg_req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign cfg_ack = cfg_ack_ff;
  assign cfg_rdata = cfg_rdata_ff;

  // Master abort handling
  wire logic ma_conv = abort_evt.valid && !abort_evt.pcix;
  wire logic ma_report = bctl_ff[`BCTL_MA_MODE];
  wire logic ma_split = abort_evt.valid && abort_evt.pcix && abort_evt.non_posted;
  wire logic ma_ones = ma_conv && !ma_report && abort_evt.is_read;
  wire logic ma_drop = ma_conv && !ma_report && !abort_evt.is_read;
  wire logic ma_tabort = ma_conv && ma_report && abort_evt.ta_possible;
  wire logic ma_serr = ma_conv && ma_report && !abort_evt.ta_possible && lower_hdr.serr_enable;
  abort_resp_t abort_resp_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      abort_resp_ff <= '0;
    end else begin
      abort_resp_ff.all_ones <= ma_ones;
      abort_resp_ff.discard_write <= ma_drop;
      abort_resp_ff.target_abort <= ma_tabort;
      abort_resp_ff.split_completion <= ma_split;
      abort_resp_ff.fill_data <= ma_ones ? `VAL_ALL_ONES : 32'h0000_0000;
    end
  end

  assign abort_resp = abort_resp_ff;

  // System error and parity
  wire logic dt_serr = any_expire && bctl_ff[`BCTL_DISCARD_SERR] && !primary_pcix_mode;
  wire logic fwd_serr = secondary_system_error_in && bctl_ff[`BCTL_SEC_SERR_EN];
  logic serr_ff;
  logic parity_ff;
  logic sec_reset_n_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      serr_ff <= 1'b0;
    end else begin
      serr_ff <= dt_serr || fwd_serr || ma_serr;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      parity_ff <= 1'b0;
    end else begin
      parity_ff <= secondary_parity_err && bctl_ff[`BCTL_PARITY_RESP];
    end
  end

  // Secondary bus stays in reset while the primary bus is in reset
  always_ff @(posedge clock) begin
    if (rst) begin
      sec_reset_n_ff <= 1'b0;
    end else begin
      sec_reset_n_ff <= !bctl_ff[`BCTL_SEC_RESET];
    end
  end

  assign primary_system_error_out = serr_ff;
  assign secondary_parity_detected = parity_ff;
  assign secondary_reset_n = sec_reset_n_ff;

  // Forwarding decode
  wire logic [63:0] qa = fwd_query.addr;
  wire logic [63:0] io_lo = {32'h0, io_base_high_ff, lower_hdr.io_base_low, 12'h000};
  wire logic [63:0] io_hi = {32'h0, io_limit_high_ff, lower_hdr.io_limit_low, 12'hFFF};
  wire logic [63:0] pf_lo = {pf_base_high_ff, lower_hdr.pf_base_low, 20'h00000};
  wire logic [63:0] pf_hi = {pf_limit_high_ff, lower_hdr.pf_limit_low, 20'hFFFFF};
  wire logic io_hit = fwd_query.is_io && in_range(qa, io_lo, io_hi);
  wire logic pf_hit = fwd_query.is_mem && in_range(qa, pf_lo, pf_hi);
  wire logic mem_hit = fwd_query.is_mem && (lower_hdr.mem_window_hit || pf_hit);
  wire logic low_64k = qa[63:16] == 48'h0;
  wire logic [63:0] qa_io10 = {54'h0, qa[9:0]};
  // Legacy VGA I/O decodes only ten bits, so aliases above 3FFh also match
  wire logic vga_io = fwd_query.is_io && low_64k &&
    (in_range(qa_io10, {54'h0, `VGA_IO_A_LO}, {54'h0, `VGA_IO_A_HI}) ||
     in_range(qa_io10, {54'h0, `VGA_IO_B_LO}, {54'h0, `VGA_IO_B_HI}));
  wire logic vga_mem = fwd_query.is_mem && in_range(qa, `VGA_MEM_LO, `VGA_MEM_HI);
  wire logic vga_fwd = bctl_ff[`BCTL_VGA_EN] &&
    ((vga_io && lower_hdr.io_enable) || (vga_mem && lower_hdr.mem_enable));
  wire logic isa_up = io_hit && bctl_ff[`BCTL_ISA_EN] && low_64k;
  wire logic win_io = io_hit && lower_hdr.io_enable && !isa_up;
  wire logic win_mem = mem_hit && lower_hdr.mem_enable;
  logic fwd_down_ff;
  logic fwd_up_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      fwd_down_ff <= 1'b0;
    end else begin
      fwd_down_ff <= vga_fwd || win_io || win_mem;
    end
  end

  // VGA forwarding wins over ISA, so one query never goes both ways
  always_ff @(posedge clock) begin
    if (rst) begin
      fwd_up_ff <= 1'b0;
    end else begin
      fwd_up_ff <= isa_up && !vga_fwd;
    end
  end

  assign fwd_downstream = fwd_down_ff;
  assign fwd_upstream = fwd_up_ff;

endmodule : bridge_config_upper_header

// file: sim/bridge_upper_asserts.sv
`timescale 1ns/100ps
module bridge_upper_asserts #(
  parameter int unsigned LONG_DISCARD_CYCLES = 32768
) (
  input wire logic clock,
  input wire logic rst,
  input wire bridge_upper_pkg::cfg_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic primary_pcix_mode,
  input wire logic secondary_pcix_mode,
  input wire logic [1:0] discard_start,
  input wire logic [1:0] discard_done,
  input wire bridge_upper_pkg::lower_hdr_t lower_hdr,
  input wire bridge_upper_pkg::abort_evt_t abort_evt,
  input wire bridge_upper_pkg::abort_resp_t abort_resp,
  input wire bridge_upper_pkg::fwd_query_t fwd_query,
  input wire logic fwd_downstream,
  input wire logic fwd_upstream,
  input wire logic secondary_system_error_in,
  input wire logic secondary_parity_err,
  input wire logic secondary_parity_detected,
  input wire logic primary_system_error_out,
  input wire logic secondary_reset_n
);
  import bridge_upper_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire req_any = cfg_req.wr | cfg_req.rd;
  wire rd_only = cfg_req.rd & ~cfg_req.wr;
  a_ack_after_req: assert property (req_any |=> cfg_ack) else $error("no ack after request");
  a_no_spare_ack: assert property (!req_any |=> !cfg_ack) else $error("ack without request");
  a_write_data_zero: assert property (cfg_req.wr && !cfg_req.rd |=> cfg_rdata == 32'h0) else $error("data after write");
  a_cap_fixed: assert property (rd_only && cfg_req.offset == 8'h34 |=> cfg_rdata == 32'h80) else $error("cap pointer");
  a_rom_zero: assert property (rd_only && cfg_req.offset == 8'h38 |=> cfg_rdata == 32'h0) else $error("rom base");
  a_pin_fixed: assert property (rd_only && cfg_req.offset == 8'h3C |=> cfg_rdata[15:8] == 8'h00 && !cfg_rdata[23])
    else $error("pin or fast b2b bit");
  a_sec_reset_bit: assert property (cfg_ack && $past(rd_only && cfg_req.offset == 8'h3C)
    |-> cfg_rdata[22] == !secondary_reset_n) else $error("secondary reset mismatch");
  a_split_on_pcix: assert property (abort_evt.valid && abort_evt.pcix && abort_evt.non_posted
    |=> abort_resp.split_completion) else $error("no split completion");
  a_ones_fill: assert property (abort_resp.all_ones |-> abort_resp.fill_data == 32'hFFFF_FFFF) else $error("fill");
  a_ta_cause: assert property (abort_resp.target_abort |-> $past(abort_evt.valid && abort_evt.ta_possible))
    else $error("target abort without cause");
  a_parity_cause: assert property (secondary_parity_detected |-> $past(secondary_parity_err))
    else $error("parity detect without error");
  cover property (abort_resp.target_abort);
  cover property (primary_system_error_out ##1 !primary_system_error_out);
  cover property (!secondary_reset_n ##1 secondary_reset_n);
endmodule : bridge_upper_asserts
bind bridge_config_upper_header bridge_upper_asserts #(.LONG_DISCARD_CYCLES(LONG_DISCARD_CYCLES)) bridge_upper_asserts_i (
  .clock, .rst, .cfg_req, .cfg_ack, .cfg_rdata, .primary_pcix_mode, .secondary_pcix_mode, .discard_start,
  .discard_done, .lower_hdr, .abort_evt, .abort_resp, .fwd_query, .fwd_downstream, .fwd_upstream,
  .secondary_system_error_in, .secondary_parity_err, .secondary_parity_detected, .primary_system_error_out,
  .secondary_reset_n);

// file: sim/host_cfg_model.sv
`timescale 1ns/100ps
module host_cfg_model (
  input wire logic clock,
  output bridge_upper_pkg::cfg_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  import bridge_upper_pkg::*;
  logic [31:0] rd_q;
  logic ack_seen;
  initial cfg_req = '0;
  // Idle cycle first, so back-to-back calls never drive twice in one step
  task automatic xfer(input logic w, input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    @(negedge clock);
    cfg_req = '{wr: w, rd: !w, offset: o, byte_en: b, wdata: d};
    @(negedge clock);
    cfg_req = '0;
    for (int i = 0; i < 4 && !cfg_ack; i++) @(negedge clock);
    ack_seen = cfg_ack;
    rd_q = cfg_rdata;
  endtask : xfer
endmodule : host_cfg_model

// file: sim/bridge_config_upper_header_tb_top.sv
`timescale 1ns/100ps
module bridge_config_upper_header_tb_top;
  import bridge_upper_pkg::*;
  localparam int unsigned LONGC = 64;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic primary_pcix_mode = 1'b0;
  logic secondary_pcix_mode = 1'b0;
  logic [1:0] discard_start = 2'b00;
  logic [1:0] discard_done = 2'b00;
  logic secondary_system_error_in = 1'b0;
  logic secondary_parity_err = 1'b0;
  lower_hdr_t lower_hdr = '{4'h1, 4'h1, 12'h000, 12'h000, 1'b0, 1'b1, 1'b1, 1'b1};
  abort_evt_t abort_evt = '0;
  fwd_query_t fwd_query = '0;
  cfg_req_t cfg_req;
  abort_resp_t abort_resp;
  logic cfg_ack, fwd_downstream, fwd_upstream, secondary_parity_detected, primary_system_error_out, secondary_reset_n;
  logic [31:0] cfg_rdata;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] ofs [6] = '{8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
  logic [31:0] onev [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h80, 32'h0, 32'h0B6F_00FF};
  always #10 clock = ~clock;
  bridge_config_upper_header #(.LONG_DISCARD_CYCLES(LONGC)) bridge_config_upper_header_i (
    .clock, .rst, .cfg_req, .cfg_ack, .cfg_rdata, .primary_pcix_mode, .secondary_pcix_mode, .discard_start,
    .discard_done, .lower_hdr, .abort_evt, .abort_resp, .fwd_query, .fwd_downstream, .fwd_upstream,
    .secondary_system_error_in, .secondary_parity_err, .secondary_parity_detected, .primary_system_error_out,
    .secondary_reset_n);
  host_cfg_model host_cfg_model_i (.clock, .cfg_req, .cfg_ack, .cfg_rdata);
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
    host_cfg_model_i.xfer(w, o, b, d);
    chk({31'h0, host_cfg_model_i.ack_seen}, 32'h1);
    if (!host_cfg_model_i.ack_seen) print_verdict;
  endtask : acc
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    acc(1'b0, o, 4'hF, 32'h0);
    chk(host_cfg_model_i.rd_q, e);
  endtask : rd
  // Counts cycles from start to the error strobe
  task automatic tmr(input int t, input int n);
    int k;
    k = 0;
    @(negedge clock);
    discard_start[t] = 1'b1;
    @(negedge clock);
    discard_start = 2'b00;
    while (!primary_system_error_out && k < 2000) begin
      @(negedge clock);
      k++;
    end
    chk(k, n);
    if (k == 2000) print_verdict;
  endtask : tmr
  task automatic ab(input logic [4:0] e, input logic [4:0] x);
    @(negedge clock);
    abort_evt = e;
    @(negedge clock);
    abort_evt = '0;
    chk({27'h0, abort_resp.all_ones, abort_resp.discard_write, abort_resp.target_abort,
         abort_resp.split_completion, primary_system_error_out}, {27'h0, x});
    chk(abort_resp.fill_data, x[4] ? 32'hFFFF_FFFF : 32'h0000_0000);
  endtask : ab
  task automatic sig(input logic [1:0] e);
    repeat (2) @(negedge clock);
    chk({30'h0, fwd_downstream, fwd_upstream}, {30'h0, e});
  endtask : sig
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    foreach (ofs[i]) rd(ofs[i], (i == 3) ? 32'h80 : 32'h0);
    foreach (ofs[i]) acc(1'b1, ofs[i], 4'hF, 32'hFFFF_FFFF);
    foreach (ofs[i]) rd(ofs[i], onev[i]);
    chk({31'h0, secondary_reset_n}, 32'h0);
    foreach (ofs[i]) acc(1'b1, ofs[i], 4'hF, 32'h0);
    @(negedge clock);
    chk({31'h0, secondary_reset_n}, 32'h1);
    acc(1'b1, 8'h28, 4'h5, 32'h1234_5678);
    rd(8'h28, 32'h0034_0078);
    acc(1'b1, 8'h30, 4'hC, 32'hABCD_1234);
    rd(8'h30, 32'hABCD_0000);
    acc(1'b1, 8'h3C, 4'h1, 32'hFF);
    rd(8'h3C, 32'hFF);
    acc(1'b1, 8'h3C, 4'h8, 32'h0800_0000);
    tmr(0, LONGC + 1);
    rd(8'h3C, 32'h0C00_00FF);
    acc(1'b1, 8'h3C, 4'h8, 32'h0C00_0000);
    rd(8'h3C, 32'h0800_00FF);
    acc(1'b1, 8'h3C, 4'h8, 32'h0B00_0000);
    tmr(0, 1025);
    tmr(1, 1025);
    acc(1'b1, 8'h3C, 4'h4, 32'h0002_0000);
    secondary_system_error_in = 1'b1;
    repeat (2) @(negedge clock);
    chk({31'h0, primary_system_error_out}, 32'h1);
    acc(1'b1, 8'h3C, 4'h4, 32'h0001_0000);
    @(negedge clock);
    chk({31'h0, primary_system_error_out}, 32'h0);
    secondary_system_error_in = 1'b0;
    for (int p = 1; p >= 0; p--) begin
      secondary_parity_err = 1'b1;
      @(negedge clock);
      secondary_parity_err = 1'b0;
      chk({31'h0, secondary_parity_detected}, p);
      acc(1'b1, 8'h3C, 4'h4, 32'h0);
    end
    ab(5'b11000, 5'b10000);
    ab(5'b10000, 5'b01000);
    ab(5'b11110, 5'b00010);
    acc(1'b1, 8'h3C, 4'h4, 32'h0020_0000);
    ab(5'b11001, 5'b00100);
    ab(5'b11000, 5'b00001);
    fwd_query = '{1'b0, 1'b1, 64'h000A_0000};
    acc(1'b1, 8'h3C, 4'h4, 32'h0008_0000);
    sig(2'b10);
    acc(1'b1, 8'h3C, 4'h4, 32'h0);
    sig(2'b00);
    fwd_query = '{1'b1, 1'b0, 64'h1000};
    acc(1'b1, 8'h3C, 4'h4, 32'h0004_0000);
    sig(2'b01);
    acc(1'b1, 8'h3C, 4'h4, 32'h0);
    sig(2'b10);
    print_verdict;
  end
endmodule : bridge_config_upper_header_tb_top
